// *** rtl/bvs_pkg.sv ***
package bvs_pkg;
  // Timing base
  localparam int CLK_MHZ = 200;
  localparam int CLK_KHZ = CLK_MHZ * 1000;
  localparam int OSC_NOM_KHZ = 1500;
  localparam int OSC_FOLD_KHZ = 300;
  localparam logic [9:0] OSC_NOM_CYC = 10'(CLK_KHZ / OSC_NOM_KHZ);
  localparam logic [9:0] OSC_FOLD_CYC = 10'(CLK_KHZ / OSC_FOLD_KHZ);
  localparam logic [9:0] FOLD_STEP_CYC = 10'h020;
  // Spread in tenths of a percent, peak-to-peak
  localparam int SPREAD_X10 [4] = '{0, 74, 148, 224};
  // Slew in uV/us, one code is about 15 mV
  localparam int STEP_UV = 15000;
  localparam int SLEW_UV_PER_US [4] = '{11300, 7500, 3800, 900};
  localparam logic [5:0] CODE_MAX = 6'h30;
  localparam int VOUT_MIN_MV = 850;
  localparam int VOUT_MAX_MV = 1550;
  // Register map and fields
  localparam logic [7:0] OFS_TARGET = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h01;
  localparam logic [7:0] OFS_TRIG = 8'h02;
  localparam logic [7:0] OFS_SPREAD = 8'h05;
  localparam int TRIG_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int SPREAD_LSB = 5;
  // Low five bits of the bus address, value arbitrary
  localparam logic [4:0] ADDR_LOW = 5'h0A;
  // Synchroniser lane positions
  localparam int SY_PEAK = 0;
  localparam int SY_REV = 1;
  localparam int SY_SLEEP = 2;
  localparam int SY_LIGHT = 3;
  localparam int SY_SHORT = 4;
  localparam int SY_OK = 5;
  localparam int SY_W = 8;

  typedef enum logic [3:0] {
    SW_TOP = 4'h1,
    SW_BOT = 4'h2,
    SW_OFF = 4'h4,
    SW_SLEEP = 4'h8
  } bvs_sw_t;

  typedef enum logic [8:0] {
    IC_IDLE = 9'h001,
    IC_ADDR = 9'h002,
    IC_ACKA = 9'h004,
    IC_REG = 9'h008,
    IC_ACKR = 9'h010,
    IC_WDAT = 9'h020,
    IC_ACKW = 9'h040,
    IC_RDAT = 9'h080,
    IC_RACK = 9'h100
  } bvs_ic_t;

  function automatic logic [11:0] slew_cycles(input logic [1:0] sel);
    slew_cycles = 12'(STEP_UV * CLK_MHZ / SLEW_UV_PER_US[sel]);
  endfunction

  function automatic logic [4:0] spread_dev(input logic [1:0] sel);
    spread_dev = 5'(int'(OSC_NOM_CYC) * SPREAD_X10[sel] / 2000);
  endfunction

  function automatic logic [5:0] clamp_code(input logic [5:0] c);
    clamp_code = (c > CODE_MAX) ? CODE_MAX : c;
  endfunction

  function automatic logic [10:0] code_to_mv(input logic [5:0] c);
    code_to_mv = 11'(VOUT_MIN_MV + int'(c) * (VOUT_MAX_MV - VOUT_MIN_MV) / int'(CODE_MAX));
  endfunction
endpackage

// *** rtl/bvs_i2c_slave.sv ***
`timescale 1ns/1ps
module bvs_i2c_slave
  import bvs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] addr_strap,
  output logic [7:0] reg_addr,
  input wire logic [7:0] rd_data,
  output logic wr_strobe,
  output logic [7:0] wr_data
);
  import bvs_pkg::*;

  typedef struct packed {
    logic [1:0] s1, s2, s3, f;
    bvs_ic_t st;
    logic [3:0] cnt;
    logic [7:0] sh, ptr;
    logic rw, ack, oe, wr;
  } bvs_ic_st_t;

  bvs_ic_st_t q, d;
  logic scl_r, scl_f, sda_v;

  assign scl_r = d.f[0] & ~q.f[0];
  assign scl_f = ~d.f[0] & q.f[0];
  assign sda_v = d.f[1];

  always_comb
  begin
    d = q;
    d.wr = 1'b0;
    d.s1 = {sda_i, scl_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 2; i++)
    begin
      if (q.s2[i] == q.s3[i])
        d.f[i] = q.s3[i];
    end
    if (d.f[0] && q.f[0] && q.f[1] != d.f[1])
    begin
      // Start or stop; repeated start restarts address phase
      d.st = d.f[1] ? IC_IDLE : IC_ADDR;
      d.cnt = 4'h0;
      d.oe = 1'b0;
    end
    else if (scl_r)
    begin
      case (q.st)
        IC_ADDR, IC_REG, IC_WDAT:
        begin
          d.sh = {q.sh[6:0], sda_v};
          d.cnt = q.cnt + 4'h1;
        end
        IC_RDAT: d.cnt = q.cnt + 4'h1;
        IC_ACKW, IC_RACK: d.ack = ~sda_v;
        default: d.cnt = q.cnt;
      endcase
    end
    else if (scl_f)
    begin
      case (q.st)
        IC_ADDR:
        begin
          if (q.cnt == 4'h8)
          begin
            d.cnt = 4'h0;
            d.rw = q.sh[0];
            d.oe = (q.sh[7:1] == {addr_strap, ADDR_LOW});
            d.st = d.oe ? IC_ACKA : IC_IDLE;
          end
        end
        IC_ACKA:
        begin
          d.st = q.rw ? IC_RDAT : IC_REG;
          d.sh = rd_data;
          d.oe = q.rw & ~rd_data[7];
        end
        IC_REG, IC_WDAT:
        begin
          if (q.cnt == 4'h8)
          begin
            d.cnt = 4'h0;
            d.oe = 1'b1;
            d.st = (q.st == IC_REG) ? IC_ACKR : IC_ACKW;
            if (q.st == IC_REG)
              d.ptr = q.sh;
          end
        end
        IC_ACKR:
        begin
          d.oe = 1'b0;
          d.st = IC_WDAT;
        end
        IC_ACKW:
        begin
          // Commit only once the ack was seen low, in the following low phase
          d.oe = 1'b0;
          d.wr = q.ack;
          d.st = IC_WDAT;
        end
        IC_RDAT:
        begin
          if (q.cnt == 4'h8)
          begin
            d.cnt = 4'h0;
            d.oe = 1'b0;
            d.st = IC_RACK;
          end
          else
          begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe = ~q.sh[6];
          end
        end
        IC_RACK:
        begin
          d.st = q.ack ? IC_RDAT : IC_IDLE;
          d.sh = rd_data;
          d.oe = q.ack & ~rd_data[7];
        end
        default: d.st = IC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, f: 2'h3, st: IC_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00,
             rw: 1'b0, ack: 1'b0, oe: 1'b0, wr: 1'b0};
    end
    else if (ce)
      q <= d;
  end

  assign sda_o = 1'b0;
  assign sda_oe = q.oe;
  assign reg_addr = q.ptr;
  assign wr_strobe = q.wr & ce;
  assign wr_data = q.sh;

  property p_commit_after_ack;
    @(posedge clock) disable iff (!rst_b)
    (ce && d.wr) |-> (q.st == IC_ACKW) && q.ack && scl_f;
  endproperty
  a_commit_after_ack: assert property (p_commit_after_ack)
    else $error("register write committed without a valid ack");
endmodule

// *** rtl/bvs_buck_ctrl.sv ***
`timescale 1ns/1ps
module bvs_buck_ctrl
  import bvs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] addr_strap,
  input wire logic peak_current_comparator,
  input wire logic current_reversal_comparator,
  input wire logic sleep_threshold_comparator,
  input wire logic light_load_mode,
  input wire logic output_short,
  input wire logic output_ok_sense,
  output logic output_ok_flag_o,
  output logic output_ok_flag_oe,
  output logic top_switch_on,
  output logic bottom_switch_on,
  output logic nonessential_off,
  output logic [5:0] dac_code,
  output logic [10:0] vout_target_mv,
  output logic ramp_busy
);
  import bvs_pkg::*;

  typedef struct packed {
    logic [SY_W-1:0] s1, s2, s3, f;
    logic [5:0] target_reg;
    logic [1:0] rate;
    logic trig;
    logic [1:0] spread;
    logic trig_prev;
    logic ramping;
    logic [5:0] ramp_target;
    logic [5:0] code;
    logic [11:0] step_cnt;
    logic [10:0] mv;
    logic [9:0] osc_cnt;
    logic [9:0] fold_per;
    logic [4:0] dither;
    logic dither_up;
    bvs_sw_t sw;
  } bvs_st_t;

  bvs_st_t q, d;
  logic [7:0] reg_addr, rd_data, wr_data;
  logic wr_strobe;
  logic [SY_W-1:0] sy_in;
  logic trig_rise, tick, peak, rev, wake, light, short_f;
  logic [10:0] period;

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  bvs_i2c_slave u_i2c (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .addr_strap(q.f[SY_W-1:SY_W-2]),
    .reg_addr(reg_addr),
    .rd_data(rd_data),
    .wr_strobe(wr_strobe),
    .wr_data(wr_data)
  );

  always_comb
  begin
    rd_data = 8'h00;
    case (reg_addr)
      OFS_TARGET: rd_data = {2'h0, q.target_reg};
      OFS_RATE: rd_data = {6'h00, q.rate};
      OFS_TRIG: rd_data = {6'h00, q.ramping, q.trig};
      OFS_SPREAD: rd_data = {1'b0, q.spread, 5'h00};
      default: rd_data = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Derived strobes
  // ------------------------------------------------------------
  assign sy_in = {addr_strap, output_ok_sense, output_short, light_load_mode,
                  sleep_threshold_comparator, current_reversal_comparator, peak_current_comparator};
  assign peak = q.f[SY_PEAK];
  assign rev = q.f[SY_REV];
  assign wake = q.f[SY_SLEEP];
  assign light = q.f[SY_LIGHT];
  assign short_f = q.f[SY_SHORT];
  assign trig_rise = q.trig & ~q.trig_prev;
  // Dither is signed around the folded period
  assign period = {1'b0, q.fold_per} + {{6{q.dither[4]}}, q.dither};
  assign tick = ({1'b0, q.osc_cnt} >= period - 11'h001);

  always_comb
  begin
    d = q;
    d.s1 = sy_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // A pin change counts only once two stages agree
    for (int i = 0; i < SY_W; i++)
    begin
      if (q.s2[i] == q.s3[i])
        d.f[i] = q.s3[i];
    end

    if (wr_strobe)
    begin
      case (reg_addr)
        OFS_TARGET: d.target_reg = wr_data[5:0];
        OFS_RATE: d.rate = wr_data[1:0];
        OFS_TRIG: d.trig = wr_data[TRIG_BIT];
        OFS_SPREAD: d.spread = wr_data[SPREAD_LSB+1:SPREAD_LSB];
        default: d.trig = q.trig;
      endcase
    end

    // Ramp engine; a retrigger keeps the present code, so no jump
    d.trig_prev = q.trig;
    if (trig_rise)
    begin
      d.ramp_target = clamp_code(q.target_reg);
      d.ramping = 1'b1;
      d.step_cnt = 12'h000;
    end
    else if (q.ramping)
    begin
      if (q.code == q.ramp_target)
        d.ramping = 1'b0;
      else if (q.step_cnt >= slew_cycles(q.rate) - 12'h001)
      begin
        d.step_cnt = 12'h000;
        d.code = (q.code < q.ramp_target) ? q.code + 6'h01 : q.code - 6'h01;
      end
      else
        d.step_cnt = q.step_cnt + 12'h001;
    end
    d.mv = code_to_mv(d.code);

    // Oscillator with foldback and triangular dither
    if (short_f)
      d.fold_per = OSC_FOLD_CYC;
    else if (tick && q.fold_per > OSC_NOM_CYC)
      d.fold_per = (q.fold_per - OSC_NOM_CYC > FOLD_STEP_CYC) ? q.fold_per - FOLD_STEP_CYC : OSC_NOM_CYC;

    if (q.sw == SW_SLEEP)
    begin
      // Oscillator parked while asleep; wake starts a fresh cycle
      d.osc_cnt = 10'h000;
      if (wake)
        d.sw = SW_TOP;
    end
    else if (tick)
    begin
      d.osc_cnt = 10'h000;
      if (q.spread == 2'h0)
        d.dither = 5'h00;
      else if (q.dither_up)
      begin
        d.dither = q.dither + 5'h01;
        if ($signed(q.dither) + 6'sh01 >= $signed({1'b0, spread_dev(q.spread)}))
          d.dither_up = 1'b0;
      end
      else
      begin
        d.dither = q.dither - 5'h01;
        if ($signed(q.dither) - 6'sh01 <= -$signed({1'b0, spread_dev(q.spread)}))
          d.dither_up = 1'b1;
      end
      d.sw = (light && !wake) ? SW_SLEEP : SW_TOP;
    end
    else
    begin
      d.osc_cnt = q.osc_cnt + 10'h001;
      case (q.sw)
        SW_TOP: if (peak) d.sw = SW_BOT;
        SW_BOT: if (rev) d.sw = SW_OFF;
        SW_OFF: d.sw = SW_OFF;
        default: d.sw = SW_OFF;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.fold_per <= OSC_NOM_CYC;
      q.mv <= code_to_mv(6'h00);
      q.sw <= SW_OFF;
    end
    else if (ce)
      q <= d;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign output_ok_flag_o = 1'b0;
  assign output_ok_flag_oe = ~q.f[SY_OK] & ~q.ramping;
  assign top_switch_on = (q.sw == SW_TOP);
  assign bottom_switch_on = (q.sw == SW_BOT);
  assign nonessential_off = (q.sw == SW_SLEEP);
  assign dac_code = q.code;
  assign vout_target_mv = q.mv;
  assign ramp_busy = q.ramping;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  property p_code_range;
    q.code <= CODE_MAX && q.ramp_target <= CODE_MAX;
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("output code above the top setting");

  property p_capture;
    (ce && trig_rise) |=> q.ramping && q.ramp_target == clamp_code($past(q.target_reg));
  endproperty
  a_capture: assert property (p_capture)
    else $error("trigger edge did not capture target");

  property p_step_pace;
    (ce && d.code != q.code) |-> q.ramping && !trig_rise && q.step_cnt == slew_cycles(q.rate) - 12'h001;
  endproperty
  a_step_pace: assert property (p_step_pace)
    else $error("code moved off the slew pacing");

  property p_mv_map;
    q.mv == code_to_mv(q.code);
  endproperty
  a_mv_map: assert property (p_mv_map)
    else $error("voltage not mapped from code");

  property p_ok_masked;
    q.ramping |-> !output_ok_flag_oe;
  endproperty
  a_ok_masked: assert property (p_ok_masked)
    else $error("fault reported during ramp");

  property p_no_spread;
    (q.spread == 2'h0 && q.fold_per == OSC_NOM_CYC && ce && tick) |=> q.dither == 5'h00;
  endproperty
  a_no_spread: assert property (p_no_spread)
    else $error("frequency moved with spread off");

  property p_fold;
    (ce && short_f) |=> q.fold_per == OSC_FOLD_CYC;
  endproperty
  a_fold: assert property (p_fold)
    else $error("no foldback on short");

  property p_top_off;
    (ce && top_switch_on && peak && !tick) |=> bottom_switch_on;
  endproperty
  a_top_off: assert property (p_top_off)
    else $error("top switch ignored peak current");

  property p_bot_off;
    (ce && bottom_switch_on && rev && !tick) |=> !bottom_switch_on && !top_switch_on;
  endproperty
  a_bot_off: assert property (p_bot_off)
    else $error("bottom switch ignored reversal");

  property p_sleep;
    (q.sw == SW_SLEEP) |-> !top_switch_on && !bottom_switch_on && nonessential_off;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("switch active during sleep");

  c_ramp_done: cover property ($fell(q.ramping));
  c_sleep_wake: cover property (q.sw == SW_SLEEP ##1 q.sw == SW_TOP);
  c_fold_recover: cover property (q.fold_per == OSC_FOLD_CYC ##[1:1000] q.fold_per == OSC_NOM_CYC);
endmodule

// *** tb/bvs_host.sv ***
`timescale 1ns/1ps
module bvs_host (
  input wire logic clock,
  input wire logic sda_w,
  output logic scl,
  output logic sda,
  output logic rd_done,
  output logic [7:0] rd_byte
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end
  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  // Quarter bit of four clocks, so no phase is under the four-clock minimum
  task automatic q(input logic c, input logic d);
    repeat (4) @(posedge clock);
    scl <= c;
    sda <= d;
  endtask
  // Data moves only while the clock is low; sampled midway through the high phase
  task automatic bx(input logic b, output logic s);
    q(1'b0, sda);
    q(1'b0, b);
    q(1'b1, b);
    repeat (4) @(posedge clock);
    s = sda_w;
  endtask
  task automatic st(input logic rep);
    if (rep)
    begin
      q(1'b0, sda);
      q(1'b0, 1'b1);
      q(1'b1, 1'b1);
    end
    q(1'b1, 1'b0);
  endtask
  task automatic sp();
    q(1'b0, sda);
    q(1'b0, 1'b0);
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
  endtask
  // Fewer than eight bits only to abort a byte on purpose
  task automatic tx(input logic [7:0] d, input int n);
    logic s;
    for (int i = 7; i > 7 - n; i--)
      bx(d[i], s);
    if (n == 8)
      bx(1'b1, s);
  endtask
  // ----------------------------------------
  // Register transfers
  // ----------------------------------------
  task automatic wr(input logic [6:0] dv, input logic [7:0] r, input logic [7:0] d, input int n);
    st(1'b0);
    tx({dv, 1'b0}, 8);
    tx(r, 8);
    tx(d, n);
    sp();
  endtask
  task automatic rd(input logic [6:0] dv, input logic [7:0] r);
    logic [7:0] v;
    logic s;
    st(1'b0);
    tx({dv, 1'b0}, 8);
    tx(r, 8);
    st(1'b1);
    tx({dv, 1'b1}, 8);
    for (int i = 7; i >= 0; i--)
      bx(1'b1, v[i]);
    bx(1'b1, s);
    sp();
    rd_byte <= v;
    rd_done <= 1'b1;
    @(posedge clock);
    rd_done <= 1'b0;
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import bvs_pkg::*;
  localparam logic [6:0] DEV = {2'h2, ADDR_LOW};
  localparam logic [7:0] REGS [4] = '{OFS_TARGET, OFS_RATE, OFS_TRIG, OFS_SPREAD};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b0;
  logic [1:0] addr_strap = 2'h2;
  logic peak = 1'b0;
  logic rev = 1'b0;
  logic wake = 1'b0;
  logic light = 1'b0;
  logic shorted = 1'b0;
  logic ok_sense = 1'b0;
  logic scl, sda, sda_o, sda_oe, okf_o, okf_oe, top, bot, ness, busy, rd_done, apk, first, gap_on;
  logic [7:0] rd_byte;
  logic [5:0] dac, prev;
  logic [10:0] mv;
  logic [7:0] exp_q [$];
  logic [5:0] code_q [$];
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 17;
  int cyc = 0;
  int last = 0;
  int t0, t1, t2, d, mn, mx, gap;
  // Open drain with pull-up
  wire sda_w = sda & !sda_oe;
  always #2.5 clock = ~clock;
  always @(posedge clock)
    cyc <= cyc + 1;
  // Comparators that follow the switches, when enabled
  always @(posedge clock)
    if (apk)
    begin
      peak <= top;
      rev <= bot;
    end
  bvs_buck_ctrl u_dut (
    .clock(clock), .rst_b(rst_b), .ce(ce), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap(addr_strap), .peak_current_comparator(peak), .current_reversal_comparator(rev),
    .sleep_threshold_comparator(wake), .light_load_mode(light), .output_short(shorted),
    .output_ok_sense(ok_sense), .output_ok_flag_o(okf_o), .output_ok_flag_oe(okf_oe), .top_switch_on(top),
    .bottom_switch_on(bot), .nonessential_off(ness), .dac_code(dac), .vout_target_mv(mv), .ramp_busy(busy)
  );
  bvs_host u_host (.clock(clock), .sda_w(sda_w), .scl(scl), .sda(sda), .rd_done(rd_done), .rd_byte(rd_byte));
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    cmp_count++;
    if (a !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(negedge clock)
  begin
    if (rd_done === 1'b1)
      chk(16'(rd_byte), 16'(exp_q.size() ? exp_q.pop_front() : 8'hEE));
    if (rst_b === 1'b1 && dac !== prev)
    begin
      chk(16'(dac), 16'(code_q.size() ? code_q.pop_front() : 6'h3F));
      chk(16'(mv), 16'(VOUT_MIN_MV + int'(dac) * (VOUT_MAX_MV - VOUT_MIN_MV) / 48));
      if (gap_on && !first)
        chk(16'(cyc - last >= gap && cyc - last <= gap + 1), 16'h0001);
      first = 1'b0;
      last = cyc;
      prev = dac;
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic rdx(input logic [7:0] r, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(DEV, r);
  endtask
  // Target is always loaded before the trigger goes from 0 to 1
  task automatic trig();
    u_host.wr(DEV, OFS_TRIG, 8'h00, 8);
    first = 1'b1;
    u_host.wr(DEV, OFS_TRIG, 8'h01, 8);
  endtask
  task automatic wend();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 30000)
    begin
      @(negedge clock);
      k++;
    end
  endtask
  task automatic wtop(output int t);
    int k;
    k = 0;
    @(negedge clock);
    while (top !== 1'b0 && k < 2000)
    begin
      @(negedge clock);
      k++;
    end
    while (top !== 1'b1 && k < 2000)
    begin
      @(negedge clock);
      k++;
    end
    t = cyc;
  endtask
  // Late target write checks that only the code at the trigger counts
  task automatic ramp(input logic [5:0] tw, input logic [1:0] rt);
    logic [5:0] t;
    logic [5:0] c;
    logic [7:0] rn;
    rn = 8'($random(seed));
    t = (tw > 6'h30) ? 6'h30 : tw;
    c = dac;
    while (c != t)
    begin
      c = (t > c) ? c + 6'h01 : c - 6'h01;
      code_q.push_back(c);
    end
    gap = STEP_UV * CLK_MHZ / SLEW_UV_PER_US[rt];
    u_host.wr(DEV, OFS_RATE, {6'h00, rt}, 8);
    rdx(OFS_RATE, {6'h00, rt});
    u_host.wr(DEV, OFS_TARGET, {rn[7:6], tw}, 8);
    rdx(OFS_TARGET, {2'h0, tw});
    trig();
    u_host.wr(DEV, OFS_TARGET, rn, 8);
    chk(16'(okf_oe), 16'h0000);
    rdx(OFS_TRIG, 8'h03);
    wend();
    chk(16'(dac), 16'(t));
    repeat (8) @(negedge clock);
    chk(16'(okf_oe), 16'h0001);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    first = 1'b0;
    gap_on = 1'b1;
    apk = 1'b0;
    prev = 6'h00;
    gap = 0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    ce <= 1'b1;
    @(negedge clock);
    chk(16'(dac), 16'h0000);
    chk(16'(mv), 16'(VOUT_MIN_MV));
    chk(16'(busy), 16'h0000);
    chk(16'({okf_o, sda_o}), 16'h0000);
    foreach (REGS[i])
      rdx(REGS[i], 8'h00);
    done("reset");
    u_host.wr(DEV, 8'h03, 8'hFF, 8);
    rdx(8'h03, 8'h00);
    u_host.wr(DEV, OFS_TARGET, 8'h2A, 4);
    rdx(OFS_TARGET, 8'h00);
    done("register access");
    ramp(6'h0A, 2'h0);
    gap_on = 1'b0;
    for (int c = 11; c <= 48; c++)
      code_q.push_back(6'(c));
    u_host.wr(DEV, OFS_TARGET, 8'h14, 8);
    trig();
    u_host.wr(DEV, OFS_TARGET, 8'hFF, 8);
    trig();
    wend();
    chk(16'(dac), 16'h0030);
    gap_on = 1'b1;
    ramp(6'h2B, 2'h1);
    ramp(6'h28, 2'h2);
    ramp(6'h26, 2'h3);
    done("ramps");
    // Peak never fires with the comparators parked, so let them follow once to see a cycle start
    apk = 1'b1;
    wtop(t0);
    apk = 1'b0;
    repeat (40) @(negedge clock);
    chk(16'({top, bot}), 16'h0002);
    @(posedge clock);
    peak <= 1'b1;
    repeat (8) @(negedge clock);
    chk(16'({top, bot}), 16'h0001);
    @(posedge clock);
    peak <= 1'b0;
    repeat (20) @(negedge clock);
    chk(16'(bot), 16'h0001);
    @(posedge clock);
    rev <= 1'b1;
    repeat (8) @(negedge clock);
    chk(16'(bot), 16'h0000);
    @(posedge clock);
    rev <= 1'b0;
    wtop(t1);
    chk(16'(t1 - t0), 16'(OSC_NOM_CYC));
    done("switching");
    apk = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      u_host.wr(DEV, OFS_SPREAD, 8'(s << SPREAD_LSB), 8);
      rdx(OFS_SPREAD, 8'(s << SPREAD_LSB));
      d = int'(OSC_NOM_CYC) * SPREAD_X10[s] / 2000;
      mn = 9999;
      mx = 0;
      wtop(t0);
      repeat (4 * d + 6)
      begin
        wtop(t1);
        mn = (t1 - t0 < mn) ? t1 - t0 : mn;
        mx = (t1 - t0 > mx) ? t1 - t0 : mx;
        t0 = t1;
      end
      chk(16'(mn), 16'(int'(OSC_NOM_CYC) - d));
      chk(16'(mx), 16'(int'(OSC_NOM_CYC) + d));
    end
    done("spread");
    u_host.wr(DEV, OFS_SPREAD, 8'h00, 8);
    @(posedge clock);
    shorted <= 1'b1;
    wtop(t0);
    wtop(t0);
    wtop(t1);
    chk(16'(t1 - t0), 16'(CLK_KHZ / OSC_FOLD_KHZ));
    @(posedge clock);
    shorted <= 1'b0;
    wtop(t0);
    wtop(t1);
    wtop(t2);
    chk(16'((t1 - t0) - (t2 - t1)), 16'(FOLD_STEP_CYC));
    repeat (20)
      wtop(t0);
    wtop(t1);
    chk(16'(t1 - t0), 16'(OSC_NOM_CYC));
    done("foldback");
    @(posedge clock);
    light <= 1'b1;
    repeat (300) @(negedge clock);
    chk(16'({ness, top, bot}), 16'h0004);
    @(posedge clock);
    wake <= 1'b1;
    t0 = cyc;
    wtop(t1);
    chk(16'(t1 - t0 < 10), 16'h0001);
    done("sleep");
    tally_and_finish();
  end
  initial
  begin
    repeat (90000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end
endmodule
